// ### hdl/iars_sequencer.sv
// Summary of operation
// (R1) pending flag holds until taken, reset, or software clear
// (R2) acceptance takes exactly eight cycles after instruction completes
// (R3) acceptance clears master enable; non-maskable blocks further acceptance
// (R4) only the taken source's pending latch is cleared
// (R5) PC and status pushed, three bytes, stack pointer minus three
// (R6) vector slot address given for entry fetch into PC
// (R7) master enable zero blocks every maskable request
// (R8) external zero has no per-source enable, only its gate
// (R9) gate low stops external-zero edges setting the latch
// (R10) only PC and status word saved by hardware
// (R11) bank selector lives in saved status, restored by returns
// (R12) maskable return restores, stack plus three, enable set
// (R13) non-maskable return sets enable only if it was one
// (R14) requests sampled in final instruction cycle
// (R15) soft trap raises software interrupt at once, highest priority
// (R16) soft trap during non-maskable service acts as no-operation
// (R17) fetch from missing address yields FF, a soft trap
// (R18) fetch from RAM or SFR area raises address-trap reset
// (R19) test-ROM range fetches never yield FF
// (R20) highest fixed priority wins, own vector per source
// (R21) reset clears latches; software clears only, never sets
// (R22) pseudo non-maskables ignore enables but never nest
// (R23) request after final-cycle sample waits for next instruction
//
// Purpose: accept interrupts and sequence returns for the core
// Assumes: core pulses i_last_cycle in each instruction's final cycle
// Notes: core performs bus transfers; this block issues the orders
`timescale 1ns/1ps
`default_nettype none
module iars_sequencer (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [15:0] i_irq_req,
    input wire logic [15:0] i_pend_clear,
    input wire logic [15:0] i_per_source_enable,
    input wire logic i_ext_irq_zero_fall,
    input wire logic i_ext_zero_gate,
    input wire logic i_last_cycle,
    input wire logic i_soft_trap_op,
    input wire logic i_maskable_return_op,
    input wire logic i_nonmaskable_return_op,
    input wire logic i_ei_op,
    input wire logic i_di_op,
    input wire logic [15:0] i_fetch_addr,
    input wire logic i_fetch,
    input wire logic i_addr_exists,
    input wire logic i_addr_is_data,
    output logic [15:0] o_irq_pending_latch,
    output logic o_master_irq_enable,
    output logic o_accepting,
    output logic o_accept_done,
    output logic [15:0] o_vector_addr,
    output logic o_push_ctx,
    output logic o_pop_ctx,
    output logic [15:0] o_sp_delta,
    output logic o_sp_dec,
    output logic o_force_ff,
    output logic o_addr_trap_reset,
    output logic o_soft_trap_nop
);
    ////////////////////////////////////////////////////////////////////
    // helpers
    // vector address of a priority slot
    function automatic logic [15:0] iars_vec(input logic [3:0] s);
        iars_vec = iars_pkg::VEC_TOP - {11'h000, s, 1'b0};
    endfunction : iars_vec

    iars_pkg::iars_state_t state_r;
    logic [15:0] pend_r;
    logic imf_r;
    logic [3:0] cnt_r;
    logic nmi_busy_r;
    logic imf_at_nmi_r;
    logic [15:0] raw_set;
    logic [15:0] eligible;
    logic [3:0] win;
    logic win_any;
    logic trap_go;
    logic take;
    logic is_pseudo;

    ////////////////////////////////////////////////////////////////////
    // request qualification
    always_comb begin
        raw_set = i_irq_req;
        // (R9) gated edge
        raw_set[iars_pkg::SRC_EXT0] = i_ext_irq_zero_fall & i_ext_zero_gate;
        raw_set[1:0] = 2'b00;
        eligible = 16'h0000;
        // (R7) master enable gate
        if (imf_r) begin
            eligible = pend_r & i_per_source_enable;
            // (R8) ext zero bypasses enable
            eligible[iars_pkg::SRC_EXT0] = pend_r[iars_pkg::SRC_EXT0];
        end
        eligible[1:0] = 2'b00;
        eligible[iars_pkg::SRC_EXT0 - 4'h1] = 1'b0;
        // (R22) watchdog ignores enables but never nests
        eligible[iars_pkg::SRC_WDT] = pend_r[iars_pkg::SRC_WDT] & ~nmi_busy_r;
        // (R3) non-maskable in service blocks all
        if (nmi_busy_r) begin
            eligible = 16'h0000;
        end
    end

    // (R20) fixed priority, lowest index wins
    always_comb begin
        win = 4'h0;
        win_any = 1'b0;
        for (int i = iars_pkg::NSRC - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                win = 4'(i);
                win_any = 1'b1;
            end
        end
    end

    // (R15) soft trap first; (R16) none while non-maskable runs
    assign trap_go = i_soft_trap_op & i_last_cycle & ~nmi_busy_r
                     & (state_r == iars_pkg::IARS_RUN);
    // (R14) sample in final cycle
    assign take = (trap_go | (win_any & i_last_cycle))
                  & (state_r == iars_pkg::IARS_RUN);
    assign is_pseudo = trap_go | (win == iars_pkg::SRC_WDT);

    ////////////////////////////////////////////////////////////////////
    // pending latches
    // (R1) hold until taken or cleared; (R21) reset clears, no set by sw
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            pend_r <= iars_pkg::PEND_RESET;
        end else begin
            // (R4) clear taken latch; new request wins over clear
            pend_r <= (pend_r & ~i_pend_clear
                       & ~((take & ~trap_go) ? (16'h0001 << win) : 16'h0000))
                      | raw_set;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // acceptance sequencer
    // (R2) eight cycles after instruction end
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            state_r <= iars_pkg::IARS_RUN;
            cnt_r <= iars_pkg::CNT_RESET;
        end else begin
            case (state_r)
                iars_pkg::IARS_RUN: begin
                    if (take) begin
                        state_r <= iars_pkg::IARS_ACCEPT;
                        cnt_r <= iars_pkg::CNT_RESET;
                    end
                end
                iars_pkg::IARS_ACCEPT: begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == iars_pkg::ACC_LAST) begin
                        state_r <= iars_pkg::IARS_RUN;
                    end
                end
                default: state_r <= iars_pkg::IARS_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // master enable and non-maskable tracking
    // (R3) clear on accept; (R12) set on maskable return
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            imf_r <= 1'b0;
            nmi_busy_r <= 1'b0;
            imf_at_nmi_r <= 1'b0;
        end else if (take) begin
            imf_r <= 1'b0;
            if (is_pseudo) begin
                nmi_busy_r <= 1'b1;
                imf_at_nmi_r <= imf_r;
            end
        end else if (i_maskable_return_op & i_last_cycle) begin
            imf_r <= 1'b1;
        end else if (i_nonmaskable_return_op & i_last_cycle) begin
            // (R13) restore only if enabled at entry
            imf_r <= imf_at_nmi_r;
            nmi_busy_r <= 1'b0;
        end else if (i_ei_op) begin
            imf_r <= 1'b1;
        end else if (i_di_op) begin
            imf_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stack and vector orders to the core
    // (R5) push PC and status, three bytes; (R10) nothing else
    // (R11) bank selector travels inside status word
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_accepting <= 1'b0;
            o_accept_done <= 1'b0;
            o_push_ctx <= 1'b0;
            o_pop_ctx <= 1'b0;
            o_sp_delta <= 16'h0000;
            o_sp_dec <= 1'b0;
            o_vector_addr <= 16'h0000;
            o_soft_trap_nop <= 1'b0;
        end else begin
            o_accepting <= take | ((state_r == iars_pkg::IARS_ACCEPT)
                                   & (cnt_r != iars_pkg::ACC_LAST));
            // (R6) entry fetched from vector slot
            o_accept_done <= (state_r == iars_pkg::IARS_ACCEPT)
                             & (cnt_r == iars_pkg::ACC_LAST);
            o_push_ctx <= take;
            // (R12) (R13) pop three bytes on either return
            o_pop_ctx <= (i_maskable_return_op | i_nonmaskable_return_op)
                         & i_last_cycle & ~take;
            o_sp_dec <= take;
            o_sp_delta <= (take | ((i_maskable_return_op
                           | i_nonmaskable_return_op) & i_last_cycle))
                          ? iars_pkg::SP_STEP : 16'h0000;
            if (take) begin
                o_vector_addr <= iars_vec(trap_go ? iars_pkg::SRC_SOFT : win);
            end
            // (R16) trap refused
            o_soft_trap_nop <= i_soft_trap_op & i_last_cycle & nmi_busy_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // address error detection on fetch
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            o_force_ff <= 1'b0;
            o_addr_trap_reset <= 1'b0;
        end else begin
            // (R17) missing address reads FF; (R19) test ROM excluded
            o_force_ff <= i_fetch & ~i_addr_exists & ~i_addr_is_data
                          & ~((i_fetch_addr >= iars_pkg::TEST_ROM_LO)
                              & (i_fetch_addr <= iars_pkg::TEST_ROM_HI));
            // (R18) fetch from data space
            o_addr_trap_reset <= i_fetch & i_addr_is_data;
        end
    end

    assign o_irq_pending_latch = pend_r;
    assign o_master_irq_enable = imf_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    // (R23) requests latched late are not taken until next final cycle
    property p_no_take_off_final;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (state_r == iars_pkg::IARS_RUN && !i_last_cycle) |=> !o_push_ctx;
    endproperty
    a_no_take_off_final: assert property (p_no_take_off_final) // (R23)
        else $error("acceptance outside a final cycle");

    property p_accept_len;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        take |=> o_accepting [*8] ##1 !o_accepting;
    endproperty
    a_accept_len: assert property (p_accept_len) // (R2)
        else $error("acceptance length not eight cycles");

    property p_imf_clear;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        take |=> !o_master_irq_enable;
    endproperty
    a_imf_clear: assert property (p_imf_clear) // (R3)
        else $error("master enable not cleared on accept");

    property p_masked;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (take && !imf_r && !trap_go) |-> win == iars_pkg::SRC_WDT;
    endproperty
    a_masked: assert property (p_masked) // (R7)
        else $error("maskable taken with enable low");

    property p_gate;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (!i_ext_zero_gate && !pend_r[3]) |=> !pend_r[3];
    endproperty
    a_gate: assert property (p_gate) // (R9)
        else $error("gated external zero set its latch");

    property p_maskable_return_op;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_maskable_return_op && i_last_cycle && !take)
        |=> o_master_irq_enable && o_pop_ctx && o_sp_delta == 16'h0003;
    endproperty
    a_maskable_return_op: assert property (p_maskable_return_op) // (R12)
        else $error("maskable return incomplete");

    property p_push;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        take |=> o_push_ctx && o_sp_dec && o_sp_delta == 16'h0003;
    endproperty
    a_push: assert property (p_push) // (R5)
        else $error("context push missing");

    property p_nest;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        nmi_busy_r |-> !(take && is_pseudo);
    endproperty
    a_nest: assert property (p_nest) // (R22)
        else $error("pseudo non-maskable nested");

    property p_testrom;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (i_fetch && i_fetch_addr >= 16'h7F80 && i_fetch_addr <= 16'h7FFF)
        |=> !o_force_ff;
    endproperty
    a_testrom: assert property (p_testrom) // (R19)
        else $error("test ROM fetch forced to trap");
endmodule : iars_sequencer
`default_nettype wire

// ### hdl/iars_pkg.sv
// Purpose: constants for the interrupt accept/return sequencer
// Assumes: 16 priority slots, slot 0 is reset
// Notes: vector addresses descend by two from the top of memory
package iars_pkg;
    localparam int unsigned NSRC = 16;
    localparam int unsigned ACCEPT_CYCLES = 8;
    localparam logic [3:0] ACC_LAST = 4'h7;
    localparam logic [3:0] SRC_SOFT = 4'h1;
    localparam logic [3:0] SRC_WDT = 4'h2;
    localparam logic [3:0] SRC_EXT0 = 4'h3;
    localparam logic [15:0] VEC_TOP = 16'hFFFE;
    localparam logic [15:0] SP_STEP = 16'h0003;
    localparam logic [7:0] SOFT_TRAP_OPCODE = 8'hFF;
    localparam logic [15:0] TEST_ROM_LO = 16'h7F80;
    localparam logic [15:0] TEST_ROM_HI = 16'h7FFF;
    localparam logic [15:0] PEND_RESET = 16'h0000;
    localparam logic [3:0] CNT_RESET = 4'h0;
    typedef enum logic [1:0] {
        IARS_RUN = 2'b00,
        IARS_ACCEPT = 2'b01
    } iars_state_t;
endpackage : iars_pkg

// ### verif/iars_core_model.sv
// Purpose: core side model, instruction ends and fetches
// Assumes: memory map set by the two parameters below
// Notes: address lines go inverted when no fetch runs
`timescale 1ns/1ps
`default_nettype none
module iars_core_model #(
    parameter logic [15:0] DATA_TOP = 16'h0440,
    parameter logic [15:0] ROM_LO = 16'h8000
) (
    input wire logic i_clk_sys,
    output logic o_last_cycle,
    output logic [2:0] o_ops,
    output logic o_fetch,
    output logic [15:0] o_fetch_addr,
    output logic o_addr_exists,
    output logic o_addr_is_data
);
    // idle levels from time zero
    initial begin
        o_last_cycle = 1'b0;
        o_ops = 3'b000;
        o_fetch = 1'b0;
        o_fetch_addr = 16'h0000;
    end
    // memory map decode follows the address lines
    assign o_addr_exists = (o_fetch_addr >= ROM_LO);
    assign o_addr_is_data = (o_fetch_addr < DATA_TOP);
    ////////////////////////////////////////////////////////////////
    // one instruction end; ops are soft trap, maskable, non-maskable
    task automatic run_instr(input logic [2:0] op);
        @(posedge i_clk_sys);
        o_last_cycle <= 1'b1;
        o_ops <= op;
        @(posedge i_clk_sys);
        o_last_cycle <= 1'b0;
        o_ops <= 3'b000;
    endtask : run_instr
    // one fetch; test area sits below program memory, so it is missing
    task automatic fetch(input logic [15:0] a);
        @(posedge i_clk_sys);
        o_fetch <= 1'b1;
        o_fetch_addr <= a;
        @(posedge i_clk_sys);
        o_fetch <= 1'b0;
        o_fetch_addr <= ~a;
    endtask : fetch
endmodule : iars_core_model
`default_nettype wire

// ### verif/tb_interrupt_accept_return_sequencer.sv
// Purpose: self-checking bench for the interrupt sequencer
// Assumes: core model paces instruction ends and fetches
// Notes: table rows first, then refusal, fetch and reset cases
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_accept_return_sequencer;
    typedef struct packed {
        logic [15:0] req, en, vec, rem;
        logic ext, gate, master_irq_enable, sw, take, nm, imf_after;
    } iars_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [15:0] req = 16'h0000, clr = 16'h0000, en = 16'h0000;
    logic ext = 1'b0, gate = 1'b0, ei = 1'b0, di = 1'b0;
    logic last, fetch, exists, isdata;
    logic [2:0] ops;
    logic [15:0] faddr, pend, vec, delta;
    logic master_irq_enable, acc, done, push, pop, dec, ff, trap, no_operation_op;
    int err_count = 0;
    int n_checks = 0;
    iars_row_t rows [10];
    logic [15:0] fa [5] = '{16'h5000, 16'h0100, 16'h7F80, 16'h7FFF,
                            16'h8000};
    logic [4:0] fx = 5'b00001;
    logic [4:0] tx = 5'b00010;
    // clock at 50 MHz
    always #10 clk = ~clk;
    iars_core_model u_core (.i_clk_sys(clk), .o_last_cycle(last),
        .o_ops(ops), .o_fetch(fetch), .o_fetch_addr(faddr),
        .o_addr_exists(exists), .o_addr_is_data(isdata));
    iars_sequencer u_dut (.i_clk_sys(clk), .i_rstn(rstn),
        .i_irq_req(req), .i_pend_clear(clr), .i_per_source_enable(en),
        .i_ext_irq_zero_fall(ext), .i_ext_zero_gate(gate),
        .i_last_cycle(last), .i_soft_trap_op(ops[2]),
        .i_maskable_return_op(ops[1]), .i_nonmaskable_return_op(ops[0]),
        .i_ei_op(ei), .i_di_op(di), .i_fetch_addr(faddr),
        .i_fetch(fetch), .i_addr_exists(exists), .i_addr_is_data(isdata),
        .o_irq_pending_latch(pend), .o_master_irq_enable(master_irq_enable),
        .o_accepting(acc), .o_accept_done(done), .o_vector_addr(vec),
        .o_push_ctx(push), .o_pop_ctx(pop), .o_sp_delta(delta),
        .o_sp_dec(dec), .o_force_ff(ff), .o_addr_trap_reset(trap),
        .o_soft_trap_nop(no_operation_op));
    ////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string nm, input logic [15:0] got, exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    // counts and verdict
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // one-cycle request pulse
    task automatic pulse(input logic [15:0] r);
        @(posedge clk);
        req <= r;
        @(posedge clk);
        req <= 16'h0000;
    endtask : pulse
    // push and vector first, eight busy cycles, done in the ninth
    task automatic chk_accept(input logic [15:0] v);
        int n;
        n = 0;
        #1;
        chk("push", push, 1'b1);
        chk("sp_dec", dec, 1'b1);
        chk("delta", delta, 16'h0003);
        chk("vector", vec, v);
        chk("imf", master_irq_enable, 1'b0);
        for (int i = 0; i < 8; i++) begin
            n += acc;
            @(posedge clk);
            #1;
        end
        chk("busy", n, 16'h0008);
        chk("done", done, 1'b1);
        chk("busy_end", acc, 1'b0);
    endtask : chk_accept
    // one table row: set up, request, end instruction, return
    task automatic run_row(input iars_row_t r);
        @(posedge clk);
        en <= r.en;
        gate <= r.gate;
        ei <= r.master_irq_enable;
        di <= ~r.master_irq_enable;
        ext <= r.ext;
        pulse(r.req);
        ext <= 1'b0;
        ei <= 1'b0;
        di <= 1'b0;
        u_core.run_instr({r.sw, 2'b00});
        if (r.take) begin
            chk_accept(r.vec);
            chk("latch", pend, r.rem);
            @(posedge clk);
            clr <= 16'hFFFF;
            @(posedge clk);
            clr <= 16'h0000;
            u_core.run_instr({1'b0, ~r.nm, r.nm});
            #1;
            chk("pop", pop, 1'b1);
            chk("pop_delta", delta, 16'h0003);
            @(posedge clk);
            #1;
            chk("imf_ret", master_irq_enable, r.imf_after);
        end else begin
            repeat (3) @(posedge clk);
            #1;
            chk("idle", acc, 1'b0);
            chk("latch", pend, r.rem);
            @(posedge clk);
            clr <= 16'hFFFF;
            @(posedge clk);
            clr <= 16'h0000;
        end
        @(posedge clk);
        #1;
        chk("cleared", pend, 16'h0000);
    endtask : run_row
    ////////////////////////////////////////////////////////////////
    // watchdog against a hang
    initial begin
        #(20 * 3000);
        err_count++;
        finish_test();
    end
    // main sequence
    initial begin
        rows = '{
            '{16'h0010, 16'hFFF0, 16'hFFF6, 16'h0000, 0, 0, 1, 0, 1, 0, 1},
            '{16'h8000, 16'h8000, 16'hFFE0, 16'h0000, 0, 0, 1, 0, 1, 0, 1},
            '{16'h0000, 16'h0000, 16'hFFF8, 16'h0000, 1, 1, 1, 0, 1, 0, 1},
            '{16'h0220, 16'hFFF0, 16'hFFF4, 16'h0200, 0, 0, 1, 0, 1, 0, 1},
            '{16'h0004, 16'h0000, 16'hFFFA, 16'h0000, 0, 0, 0, 0, 1, 1, 0},
            '{16'h0000, 16'h0000, 16'hFFFC, 16'h0000, 0, 0, 1, 1, 1, 1, 1},
            '{16'h0010, 16'hFFF0, 16'h0000, 16'h0010, 0, 0, 0, 0, 0, 0, 0},
            '{16'h0010, 16'h0000, 16'h0000, 16'h0010, 0, 0, 1, 0, 0, 0, 0},
            '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 1, 0, 1, 0, 0, 0, 0},
            '{16'h0010, 16'hFFF0, 16'hFFFC, 16'h0010, 0, 0, 1, 1, 1, 1, 1}};
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_latch", pend, 16'h0000);
        chk("rst_busy", acc, 1'b0);
        for (int i = 0; i < 10; i++) begin
            run_row(rows[i]);
            $display("test row %0d done", i);
        end
        // soft trap inside watchdog service acts as no-op
        pulse(16'h0004);
        u_core.run_instr(3'b000);
        chk_accept(16'hFFFA);
        u_core.run_instr(3'b100);
        #1;
        chk("nop", no_operation_op, 1'b1);
        chk("nop_push", push, 1'b0);
        u_core.run_instr(3'b001);
        $display("test soft trap in service done");
        // request raised with the final cycle waits one instruction
        fork
            u_core.run_instr(3'b000);
            pulse(16'h0010);
        join
        #1;
        chk("late", push, 1'b0);
        chk("held", pend, 16'h0010);
        u_core.run_instr(3'b000);
        chk_accept(16'hFFF6);
        u_core.run_instr(3'b010);
        $display("test late request done");
        // fetch decode: missing, data, test area ends, program
        for (int i = 0; i < 5; i++) begin
            u_core.fetch(fa[i]);
            #1;
            chk("force_ff", ff, fx[i]);
            chk("trap", trap, tx[i]);
        end
        $display("test fetch areas done");
        // same-cycle set beats clear, then reset wipes latches
        @(posedge clk);
        req <= 16'h0010;
        clr <= 16'h0010;
        @(posedge clk);
        req <= 16'h0000;
        clr <= 16'h0000;
        rstn <= 1'b0;
        #1;
        chk("set_wins", pend, 16'h0010);
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        #1;
        chk("rst_latch2", pend, 16'h0000);
        $display("test reset done");
        finish_test();
    end
endmodule : tb_interrupt_accept_return_sequencer
`default_nettype wire
